/* File: core/llf_flag_bank.sv */
// Lock-protected configuration, lock status and sticky fault results.
// Assumes a synchronous register port with read data one cycle after the strobe.
`timescale 1ns/100ps
//
// Contract
// - Mask lock command sets mask lock flag; protected fields refuse changes.
// - Mask unlock command clears mask lock flag; fields writable again.
// - Mask lock covers enable, three detect masks and threshold selects, 12 outputs.
// - Any system reset clears every lock flag.
// - Lock flags are returned on the lock status read.
// - PWM setup lock blocks channel select, step count and frame rate.
// - PWM setup unlock makes those fields writable again.
// - Duty lock blocks all six ten-bit duty values.
// - Duty unlock makes the six duty values writable again.
// - Control lock blocks both control words.
// - Control unlock makes both control words writable again.
// - Two-bit resistor diagnosis code is held and readable.
// - Power-on loads diagnosis code 11; status reset command makes it 01.
// - Supply short result bit per output sets and stays set.
// - Supply short results readable, set by power-on, cleared by status reset.
// - Ground short result bit per output sets and stays set.
// - Ground short results readable, set by power-on, cleared by status reset.
// - Result bit n-1 belongs to output pin n.
// - Current lock blocks all twelve eight-bit current codes.
module llf_flag_bank (
  // Clock and reset
  input  wire logic                                        clk_sys,
  input  wire logic                                        rst_n,
  input  wire logic                                        voltage_detect_reset,
  input  wire logic                                        thermal_shutdown_trip,
  // Register port
  input  wire logic [llf_pkg::AW-1:0]                      reg_addr,
  input  wire logic [llf_pkg::DW-1:0]                      reg_wdata,
  input  wire logic                                        reg_wr,
  input  wire logic                                        reg_rd,
  output logic      [llf_pkg::DW-1:0]                      reg_rdata,
  // Detector inputs, bit n-1 for output pin n
  input  wire logic [llf_pkg::NOUT-1:0]                    supply_short_detect,
  input  wire logic [llf_pkg::NOUT-1:0]                    ground_short_detect,
  input  wire logic                                        resistor_diag_valid,
  input  wire logic [1:0]                                  resistor_diag_in,
  // Configuration outputs
  output logic      [llf_pkg::NOUT-1:0]                    output_enable_mask,
  output logic      [llf_pkg::NOUT-1:0]                    supply_short_detect_mask,
  output logic      [llf_pkg::NOUT-1:0]                    ground_short_detect_mask,
  output logic      [llf_pkg::NOUT-1:0]                    open_detect_mask,
  output logic      [llf_pkg::NOUT*llf_pkg::THR_W-1:0]     supply_short_threshold_sel,
  output logic      [llf_pkg::NOUT*llf_pkg::CHSEL_W-1:0]   pwm_channel_select,
  output logic      [llf_pkg::STEP_W-1:0]                  pwm_step_count,
  output logic      [llf_pkg::FRAME_W-1:0]                 pwm_frame_rate,
  output logic      [llf_pkg::NPWM*llf_pkg::DUTY_W-1:0]    pwm_duty_value,
  output logic      [llf_pkg::NOUT*llf_pkg::CUR_W-1:0]     output_current_code,
  output logic      [llf_pkg::CTRL1_W-1:0]                 ctrl1_word,
  output logic      [llf_pkg::CTRL2_W-1:0]                 ctrl2_word,
  // Status outputs
  output logic      [llf_pkg::NLOCK-1:0]                   lock_flags,
  output logic      [llf_pkg::NOUT-1:0]                    supply_short_result,
  output logic      [llf_pkg::NOUT-1:0]                    ground_short_result,
  output logic      [1:0]                                  resistor_diag_code
);

  // Configuration state
  logic [llf_pkg::NOUT-1:0]           oe_mask;
  logic [llf_pkg::NOUT-1:0]           vsh_mask;
  logic [llf_pkg::NOUT-1:0]           vsl_mask;
  logic [llf_pkg::NOUT-1:0]           open_mask;
  logic [llf_pkg::NOUT*llf_pkg::THR_W-1:0] thr;
  logic [llf_pkg::STEP_W-1:0]         step;
  logic [llf_pkg::FRAME_W-1:0]        frame;
  logic [llf_pkg::CTRL1_W-1:0]        ctrl1;
  logic [llf_pkg::CTRL2_W-1:0]        ctrl2;
  logic [llf_pkg::CHSEL_W-1:0]        chsel [llf_pkg::NOUT];
  logic [llf_pkg::CUR_W-1:0]          cur   [llf_pkg::NOUT];
  logic [llf_pkg::DUTY_W-1:0]         duty  [llf_pkg::NPWM];

  logic [llf_pkg::NOUT-1:0]           next_oe_mask;
  logic [llf_pkg::NOUT-1:0]           next_vsh_mask;
  logic [llf_pkg::NOUT-1:0]           next_vsl_mask;
  logic [llf_pkg::NOUT-1:0]           next_open_mask;
  logic [llf_pkg::NOUT*llf_pkg::THR_W-1:0] next_thr;
  logic [llf_pkg::STEP_W-1:0]         next_step;
  logic [llf_pkg::FRAME_W-1:0]        next_frame;
  logic [llf_pkg::CTRL1_W-1:0]        next_ctrl1;
  logic [llf_pkg::CTRL2_W-1:0]        next_ctrl2;
  logic [llf_pkg::CHSEL_W-1:0]        next_chsel [llf_pkg::NOUT];
  logic [llf_pkg::CUR_W-1:0]          next_cur   [llf_pkg::NOUT];
  logic [llf_pkg::DUTY_W-1:0]         next_duty  [llf_pkg::NPWM];

  // Status and read state
  logic [1:0]               diag;
  logic [1:0]               next_diag;
  logic [llf_pkg::DW-1:0]   next_rdata;
  logic [llf_pkg::NLOCK-1:0] lock;

  // Command decode
  logic cmd_wr;
  logic por;
  logic soft_rst;
  logic status_clr;
  logic sys_reset;

  // Address match against an indexed register array
  function automatic logic addr_hit(input logic [llf_pkg::AW-1:0] addr,
                                    input logic [llf_pkg::AW-1:0] base,
                                    input int                     idx);
    addr_hit = (addr == base + llf_pkg::AW'(idx));
  endfunction

  // Commands arrive as writes to the command word
  assign cmd_wr     = reg_wr && (reg_addr == llf_pkg::ADDR_CMD);
  assign soft_rst   = cmd_wr && (reg_wdata[7:0] == llf_pkg::CMD_SOFT_RESET);
  assign status_clr = cmd_wr && (reg_wdata[7:0] == llf_pkg::CMD_RST_STATUS);
  assign por        = voltage_detect_reset;
  assign sys_reset  = por || soft_rst || thermal_shutdown_trip;

  // Lock flags
  llf_lock_bank u_locks (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .sys_reset (sys_reset),
    .cmd_valid (cmd_wr),
    .cmd_code  (reg_wdata[7:0]),
    .lock      (lock)
  );

  // Sticky supply short results, bit n-1 is pin n
  llf_sticky_vec u_vsh_res (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .por     (por),
    .clear   (status_clr),
    .set     (supply_short_detect & ~vsh_mask),
    .q       (supply_short_result)
  );

  // Sticky ground short results, bit n-1 is pin n
  llf_sticky_vec u_vsl_res (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .por     (por),
    .clear   (status_clr),
    .set     (ground_short_detect & ~vsl_mask),
    .q       (ground_short_result)
  );

  // Configuration writes, each field gated by its own lock
  always_comb begin
    next_oe_mask   = oe_mask;
    next_vsh_mask  = vsh_mask;
    next_vsl_mask  = vsl_mask;
    next_open_mask = open_mask;
    next_thr       = thr;
    next_step      = step;
    next_frame     = frame;
    next_ctrl1     = ctrl1;
    next_ctrl2     = ctrl2;
    next_chsel     = chsel;
    next_cur       = cur;
    next_duty      = duty;
    if (reg_wr) begin
      if (!lock[llf_pkg::LK_M]) begin
        if (reg_addr == llf_pkg::ADDR_OE_MASK) begin
          next_oe_mask = reg_wdata[llf_pkg::NOUT-1:0];
        end else if (reg_addr == llf_pkg::ADDR_VSH_MASK) begin
          next_vsh_mask = reg_wdata[llf_pkg::NOUT-1:0];
        end else if (reg_addr == llf_pkg::ADDR_VSL_MASK) begin
          next_vsl_mask = reg_wdata[llf_pkg::NOUT-1:0];
        end else if (reg_addr == llf_pkg::ADDR_OPEN_MASK) begin
          next_open_mask = reg_wdata[llf_pkg::NOUT-1:0];
        end else if (reg_addr == llf_pkg::ADDR_THR_LO) begin
          next_thr[llf_pkg::THR_LO*llf_pkg::THR_W-1:0] = reg_wdata;
        end else if (reg_addr == llf_pkg::ADDR_THR_HI) begin
          next_thr[llf_pkg::NOUT*llf_pkg::THR_W-1:llf_pkg::THR_LO*llf_pkg::THR_W] =
            reg_wdata[7:0];
        end
      end
      if (!lock[llf_pkg::LK_P]) begin
        if (reg_addr == llf_pkg::ADDR_PWM_SETUP) begin
          next_step  = reg_wdata[llf_pkg::PWM_STEP_LSB +: llf_pkg::STEP_W];
          next_frame = reg_wdata[llf_pkg::PWM_FRAME_LSB +: llf_pkg::FRAME_W];
        end
        for (int i = 0; i < llf_pkg::NOUT; i++) begin
          if (addr_hit(reg_addr, llf_pkg::ADDR_CHSEL_BASE, i)) begin
            next_chsel[i] = reg_wdata[llf_pkg::CHSEL_W-1:0];
          end
        end
      end
      if (!lock[llf_pkg::LK_W]) begin
        for (int i = 0; i < llf_pkg::NPWM; i++) begin
          if (addr_hit(reg_addr, llf_pkg::ADDR_DUTY_BASE, i)) begin
            next_duty[i] = reg_wdata[llf_pkg::DUTY_W-1:0];
          end
        end
      end
      if (!lock[llf_pkg::LK_C]) begin
        for (int i = 0; i < llf_pkg::NOUT; i++) begin
          if (addr_hit(reg_addr, llf_pkg::ADDR_CUR_BASE, i)) begin
            next_cur[i] = reg_wdata[llf_pkg::CUR_W-1:0];
          end
        end
      end
      if (!lock[llf_pkg::LK_R]) begin
        if (reg_addr == llf_pkg::ADDR_CTRL1) begin
          next_ctrl1 = reg_wdata[llf_pkg::CTRL1_W-1:0];
        end else if (reg_addr == llf_pkg::ADDR_CTRL2) begin
          next_ctrl2 = reg_wdata[llf_pkg::CTRL2_W-1:0];
        end
      end
    end
  end

  // Register the configuration; it survives every reset but the pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oe_mask   <= llf_pkg::MASK_RST;
      vsh_mask  <= llf_pkg::MASK_RST;
      vsl_mask  <= llf_pkg::MASK_RST;
      open_mask <= llf_pkg::MASK_RST;
      thr       <= '0;
      step      <= '0;
      frame     <= '0;
      ctrl1     <= '0;
      ctrl2     <= '0;
      chsel     <= '{default: '0};
      cur       <= '{default: '0};
      duty      <= '{default: '0};
    end else begin
      oe_mask   <= next_oe_mask;
      vsh_mask  <= next_vsh_mask;
      vsl_mask  <= next_vsl_mask;
      open_mask <= next_open_mask;
      thr       <= next_thr;
      step      <= next_step;
      frame     <= next_frame;
      ctrl1     <= next_ctrl1;
      ctrl2     <= next_ctrl2;
      chsel     <= next_chsel;
      cur       <= next_cur;
      duty      <= next_duty;
    end
  end

  // Resistor diagnosis code; a new result wins over the status reset
  always_comb begin
    if (por) begin
      next_diag = llf_pkg::DIAG_POR;
    end else if (resistor_diag_valid) begin
      next_diag = resistor_diag_in;
    end else if (status_clr) begin
      next_diag = llf_pkg::DIAG_CLR;
    end else begin
      next_diag = diag;
    end
  end

  // Register the diagnosis code
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      diag <= llf_pkg::DIAG_POR;
    end else begin
      diag <= next_diag;
    end
  end

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    next_rdata = llf_pkg::CFG_RST;
    if (reg_addr == llf_pkg::ADDR_LOCKS) begin
      next_rdata[llf_pkg::NLOCK-1:0] = lock;
    end else if (reg_addr == llf_pkg::ADDR_OE_MASK) begin
      next_rdata[llf_pkg::NOUT-1:0] = oe_mask;
    end else if (reg_addr == llf_pkg::ADDR_VSH_MASK) begin
      next_rdata[llf_pkg::NOUT-1:0] = vsh_mask;
    end else if (reg_addr == llf_pkg::ADDR_VSL_MASK) begin
      next_rdata[llf_pkg::NOUT-1:0] = vsl_mask;
    end else if (reg_addr == llf_pkg::ADDR_OPEN_MASK) begin
      next_rdata[llf_pkg::NOUT-1:0] = open_mask;
    end else if (reg_addr == llf_pkg::ADDR_THR_LO) begin
      next_rdata = thr[llf_pkg::THR_LO*llf_pkg::THR_W-1:0];
    end else if (reg_addr == llf_pkg::ADDR_THR_HI) begin
      next_rdata[7:0] =
        thr[llf_pkg::NOUT*llf_pkg::THR_W-1:llf_pkg::THR_LO*llf_pkg::THR_W];
    end else if (reg_addr == llf_pkg::ADDR_PWM_SETUP) begin
      next_rdata[llf_pkg::PWM_STEP_LSB +: llf_pkg::STEP_W]   = step;
      next_rdata[llf_pkg::PWM_FRAME_LSB +: llf_pkg::FRAME_W] = frame;
    end else if (reg_addr == llf_pkg::ADDR_CTRL1) begin
      next_rdata[llf_pkg::CTRL1_W-1:0] = ctrl1;
    end else if (reg_addr == llf_pkg::ADDR_CTRL2) begin
      next_rdata[llf_pkg::CTRL2_W-1:0] = ctrl2;
    end else if (reg_addr == llf_pkg::ADDR_DIAG) begin
      next_rdata[1:0] = diag;
    end else if (reg_addr == llf_pkg::ADDR_VSH_RES) begin
      next_rdata[llf_pkg::NOUT-1:0] = supply_short_result;
    end else if (reg_addr == llf_pkg::ADDR_VSL_RES) begin
      next_rdata[llf_pkg::NOUT-1:0] = ground_short_result;
    end else begin
      for (int i = 0; i < llf_pkg::NOUT; i++) begin
        if (addr_hit(reg_addr, llf_pkg::ADDR_CHSEL_BASE, i)) begin
          next_rdata[llf_pkg::CHSEL_W-1:0] = chsel[i];
        end
        if (addr_hit(reg_addr, llf_pkg::ADDR_CUR_BASE, i)) begin
          next_rdata[llf_pkg::CUR_W-1:0] = cur[i];
        end
      end
      for (int i = 0; i < llf_pkg::NPWM; i++) begin
        if (addr_hit(reg_addr, llf_pkg::ADDR_DUTY_BASE, i)) begin
          next_rdata[llf_pkg::DUTY_W-1:0] = duty[i];
        end
      end
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  // Flatten the arrays onto the configuration outputs
  always_comb begin
    for (int i = 0; i < llf_pkg::NOUT; i++) begin
      pwm_channel_select[i*llf_pkg::CHSEL_W +: llf_pkg::CHSEL_W] = chsel[i];
      output_current_code[i*llf_pkg::CUR_W +: llf_pkg::CUR_W]    = cur[i];
    end
    for (int i = 0; i < llf_pkg::NPWM; i++) begin
      pwm_duty_value[i*llf_pkg::DUTY_W +: llf_pkg::DUTY_W] = duty[i];
    end
  end

  // Direct register outputs
  assign output_enable_mask         = oe_mask;
  assign supply_short_detect_mask   = vsh_mask;
  assign ground_short_detect_mask   = vsl_mask;
  assign open_detect_mask           = open_mask;
  assign supply_short_threshold_sel = thr;
  assign pwm_step_count             = step;
  assign pwm_frame_rate             = frame;
  assign ctrl1_word                 = ctrl1;
  assign ctrl2_word                 = ctrl2;
  assign lock_flags                 = lock;
  assign resistor_diag_code         = diag;

endmodule

/* File: core/llf_pkg.sv */
// Constants shared by the lock and fault result flag bank.
// Assumes one 100 MHz clock and a plain address/strobe register port.
package llf_pkg;

  // Sizes
  localparam int NOUT    = 12;
  localparam int NPWM    = 6;
  localparam int AW      = 8;
  localparam int DW      = 16;
  localparam int NLOCK   = 5;
  localparam int CHSEL_W = 3;
  localparam int CUR_W   = 8;
  localparam int DUTY_W  = 10;
  localparam int THR_W   = 2;
  localparam int STEP_W  = 2;
  localparam int FRAME_W = 4;
  localparam int CTRL1_W = 6;
  localparam int CTRL2_W = 7;
  localparam int THR_LO  = 8;

  // Register word addresses
  localparam logic [AW-1:0] ADDR_CMD        = 8'h00;
  localparam logic [AW-1:0] ADDR_LOCKS      = 8'h01;
  localparam logic [AW-1:0] ADDR_OE_MASK    = 8'h02;
  localparam logic [AW-1:0] ADDR_VSH_MASK   = 8'h03;
  localparam logic [AW-1:0] ADDR_VSL_MASK   = 8'h04;
  localparam logic [AW-1:0] ADDR_OPEN_MASK  = 8'h05;
  localparam logic [AW-1:0] ADDR_THR_LO     = 8'h06;
  localparam logic [AW-1:0] ADDR_THR_HI     = 8'h07;
  localparam logic [AW-1:0] ADDR_PWM_SETUP  = 8'h0c;
  localparam logic [AW-1:0] ADDR_CTRL1      = 8'h0d;
  localparam logic [AW-1:0] ADDR_CTRL2      = 8'h0e;
  localparam logic [AW-1:0] ADDR_CHSEL_BASE = 8'h10;
  localparam logic [AW-1:0] ADDR_CUR_BASE   = 8'h20;
  localparam logic [AW-1:0] ADDR_DUTY_BASE  = 8'h30;
  localparam logic [AW-1:0] ADDR_DIAG       = 8'h40;
  localparam logic [AW-1:0] ADDR_VSH_RES    = 8'h41;
  localparam logic [AW-1:0] ADDR_VSL_RES    = 8'h42;

  // Field positions
  localparam int PWM_STEP_LSB  = 0;
  localparam int PWM_FRAME_LSB = 2;

  // Lock flag positions in the lock status word
  localparam int LK_C = 0;
  localparam int LK_M = 1;
  localparam int LK_P = 2;
  localparam int LK_W = 3;
  localparam int LK_R = 4;

  // Command codes; lock i is CMD_LOCK_BASE+2i, its unlock one above
  localparam logic [7:0] CMD_LOCK_BASE  = 8'h10;
  localparam logic [7:0] CMD_RST_STATUS = 8'h20;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h30;

  // Reset values
  localparam logic [1:0]      DIAG_POR  = 2'h3;
  localparam logic [1:0]      DIAG_CLR  = 2'h1;
  localparam logic [NOUT-1:0] MASK_RST  = 12'h000;
  localparam logic [NOUT-1:0] RES_POR   = 12'hfff;
  localparam logic [DW-1:0]   CFG_RST   = 16'h0000;

endpackage

/* File: core/llf_lock_bank.sv */
// Five write-protect lock flags driven by lock and unlock commands.
// Assumes cmd_valid is a one-cycle strobe and sys_reset a synchronous pulse.
`timescale 1ns/100ps
module llf_lock_bank (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       sys_reset,
  // Command strobe
  input  wire logic                       cmd_valid,
  input  wire logic [7:0]                 cmd_code,
  // Lock state
  output logic      [llf_pkg::NLOCK-1:0]  lock
);

  logic [llf_pkg::NLOCK-1:0] next_lock;

  // Each lock has its own set and clear code; any system reset unlocks all
  always_comb begin
    next_lock = lock;
    if (sys_reset) begin
      next_lock = '0;
    end else if (cmd_valid) begin
      for (int i = 0; i < llf_pkg::NLOCK; i++) begin
        if (cmd_code == llf_pkg::CMD_LOCK_BASE + 8'(2 * i)) begin
          next_lock[i] = 1'b1;
        end else if (cmd_code == llf_pkg::CMD_LOCK_BASE + 8'(2 * i + 1)) begin
          next_lock[i] = 1'b0;
        end
      end
    end
  end

  // Register the lock flags
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock <= '0;
    end else begin
      lock <= next_lock;
    end
  end

endmodule

/* File: core/llf_sticky_vec.sv */
// One sticky fault result bit per output, set high by power-on reset.
// Assumes por and clear are synchronous one-cycle pulses.
`timescale 1ns/100ps
module llf_sticky_vec (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      por,
  // Events
  input  wire logic                      clear,
  input  wire logic [llf_pkg::NOUT-1:0]  set,
  // Result
  output logic      [llf_pkg::NOUT-1:0]  q
);

  logic [llf_pkg::NOUT-1:0] next_q;

  // A detection in the clearing cycle still sets its bit
  always_comb begin
    if (por) begin
      next_q = llf_pkg::RES_POR;
    end else begin
      next_q = (clear ? '0 : q) | set;
    end
  end

  // Register the results
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= llf_pkg::RES_POR;
    end else begin
      q <= next_q;
    end
  end

endmodule

/* File: dv/llf_host_model.sv */
// Host controller model: issues register writes and reads.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/100ps
module llf_host_model (
  // Clock
  input  wire logic                   clk_sys,
  // Register port
  output logic      [llf_pkg::AW-1:0] reg_addr,
  output logic      [llf_pkg::DW-1:0] reg_wdata,
  output logic                        reg_wr,
  output logic                        reg_rd,
  input  wire logic [llf_pkg::DW-1:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // One-cycle write strobe, also carries commands at address zero
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read strobe; data settle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

/* File: dv/llf_flag_bank_checker.sv */
// Port-level assertions for the lock and fault result flag bank.
// Assumes one clock domain and the register map of the shared package.
`timescale 1ns/100ps
module llf_flag_bank_checker (
  // Clock and reset
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire logic                        voltage_detect_reset,
  input wire logic                        thermal_shutdown_trip,
  // Register port
  input wire logic [llf_pkg::AW-1:0]      reg_addr,
  input wire logic [llf_pkg::DW-1:0]      reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [llf_pkg::DW-1:0]      reg_rdata,
  // Watched state
  input wire logic [llf_pkg::NOUT-1:0]    ground_short_detect,
  input wire logic                        resistor_diag_valid,
  input wire logic [llf_pkg::NOUT-1:0]    output_enable_mask,
  input wire logic [llf_pkg::STEP_W-1:0]  pwm_step_count,
  input wire logic [llf_pkg::FRAME_W-1:0] pwm_frame_rate,
  input wire logic [llf_pkg::NLOCK-1:0]   lock_flags,
  input wire logic [llf_pkg::NOUT-1:0]    supply_short_result,
  input wire logic [llf_pkg::NOUT-1:0]    ground_short_result,
  input wire logic [1:0]                  resistor_diag_code
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Command decode; calm means neither voltage detect nor thermal trip fires
  wire cmd_wr = reg_wr && reg_addr == 8'h00;
  wire calm   = !voltage_detect_reset && !thermal_shutdown_trip;
  a_mask_lock: assert property (calm && cmd_wr && reg_wdata[7:0] == 8'h12 |=> lock_flags[1])
    else $error("mask lock flag not set");
  a_mask_unlock: assert property (cmd_wr && reg_wdata[7:0] == 8'h13 |=> !lock_flags[1])
    else $error("mask lock flag not cleared");
  a_mask_hold: assert property (lock_flags[1] && reg_wr && reg_addr == 8'h02 |=> $stable(output_enable_mask))
    else $error("locked enable mask changed");
  a_pwm_hold: assert property (lock_flags[2] && reg_wr && reg_addr == 8'h0c
    |=> $stable({pwm_frame_rate, pwm_step_count})) else $error("locked pwm setup changed");
  a_mask_write: assert property (!lock_flags[1] && reg_wr && reg_addr == 8'h02
    |=> output_enable_mask == $past(reg_wdata[11:0])) else $error("enable mask not written");
  a_lock_clear: assert property (thermal_shutdown_trip
    || (cmd_wr && reg_wdata[7:0] == 8'h30) |=> lock_flags == 5'h00)
    else $error("locks survive reset");
  a_voltage_detect_reset_por: assert property (voltage_detect_reset |=> lock_flags == 5'h00
    && supply_short_result == 12'hfff && resistor_diag_code == 2'h3) else $error("power-on values");
  a_sticky_keep: assert property (!(cmd_wr && reg_wdata[7:0] == 8'h20)
    |=> (supply_short_result & $past(supply_short_result)) == $past(supply_short_result))
    else $error("supply result bit dropped");
  a_status_clear: assert property (calm && cmd_wr && reg_wdata[7:0] == 8'h20
    && !resistor_diag_valid && ground_short_detect == 12'h000
    |=> ground_short_result == 12'h000 && resistor_diag_code == 2'h1)
    else $error("status reset values");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
endmodule
bind llf_flag_bank llf_flag_bank_checker u_chk (.clk_sys, .rst_n, .voltage_detect_reset,
  .thermal_shutdown_trip, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ground_short_detect,
  .resistor_diag_valid, .output_enable_mask, .pwm_step_count, .pwm_frame_rate, .lock_flags,
  .supply_short_result, .ground_short_result, .resistor_diag_code);

/* File: dv/llf_testbench.sv */
// Self-checking bench for the lock and fault result flag bank.
// Assumes the host model drives the register port; bench drives the rest.
`timescale 1ns/100ps
module testbench;
  logic        clk_sys, rst_n, voltage_detect_reset, thermal_shutdown_trip;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, resistor_diag_valid;
  logic [1:0]  resistor_diag_in;
  logic [11:0] supply_short_detect, ground_short_detect, supply_short_result;
  int          n_fail, samples_checked, cycles;
  // First and last address guarded by each lock
  logic [7:0]  lock_span [5][2] = '{'{8'h20, 8'h2b}, '{8'h02, 8'h07}, '{8'h0c, 8'h1b},
                                    '{8'h30, 8'h35}, '{8'h0d, 8'h0e}};
  llf_host_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  llf_flag_bank dut (.clk_sys, .rst_n, .voltage_detect_reset, .thermal_shutdown_trip,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .supply_short_detect,
    .ground_short_detect, .resistor_diag_valid, .resistor_diag_in, .output_enable_mask(),
    .supply_short_detect_mask(), .ground_short_detect_mask(), .open_detect_mask(),
    .supply_short_threshold_sel(), .pwm_channel_select(), .pwm_step_count(), .pwm_frame_rate(),
    .pwm_duty_value(), .output_current_code(), .ctrl1_word(), .ctrl2_word(), .lock_flags(),
    .supply_short_result, .ground_short_result(), .resistor_diag_code());
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk($sformatf("addr %h", a), exp, d);
  endtask
  task automatic cmd(input logic [7:0] c);
    host.wr(8'h00, {8'h00, c});
  endtask
  // Lock, refused write, unlock, accepted write, for every lock
  task automatic t_locks();
    logic [7:0] a;
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 2; k++) begin
        a = lock_span[i][k];
        host.wr(a, 16'h0005);
        cmd(8'h10 + 8'(2 * i));
        rd_chk(8'h01, 16'(1 << i));
        host.wr(a, 16'h0002);
        rd_chk(a, 16'h0005);
        cmd(8'h11 + 8'(2 * i));
        host.wr(a, 16'h0002);
        rd_chk(a, 16'h0002);
      end
    end
    host.wr(8'h7f, 16'hffff);
    rd_chk(8'h7f, 16'h0000);
    $display("t_locks done");
  endtask
  // Software reset, thermal trip and voltage detector each clear all locks
  task automatic t_resets();
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 5; i++) cmd(8'h10 + 8'(2 * i));
      rd_chk(8'h01, 16'h001f);
      if (s == 0) cmd(8'h30);
      else begin
        @(posedge clk_sys);
        thermal_shutdown_trip <= (s == 1);
        voltage_detect_reset  <= (s == 2);
        @(posedge clk_sys);
        thermal_shutdown_trip <= 1'b0;
        voltage_detect_reset  <= 1'b0;
      end
      rd_chk(8'h01, 16'h0000);
    end
    rd_chk(8'h41, 16'h0fff);
    rd_chk(8'h42, 16'h0fff);
    rd_chk(8'h40, 16'h0003);
    $display("t_resets done");
  endtask
  // Status reset, then short pulses that must stick per unmasked pin
  task automatic t_sticky();
    cmd(8'h20);
    rd_chk(8'h41, 16'h0000);
    rd_chk(8'h42, 16'h0000);
    rd_chk(8'h40, 16'h0001);
    host.wr(8'h03, 16'h0001);
    @(posedge clk_sys);
    supply_short_detect <= 12'h801;
    ground_short_detect <= 12'h002;
    resistor_diag_valid <= 1'b1;
    resistor_diag_in    <= 2'h2;
    @(posedge clk_sys);
    supply_short_detect <= 12'h000;
    ground_short_detect <= 12'h000;
    resistor_diag_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd_chk(8'h41, 16'h0800);
    rd_chk(8'h42, 16'h0002);
    rd_chk(8'h40, 16'h0002);
    chk("supply result port", 16'h0800, {4'h0, supply_short_result});
    $display("t_sticky done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Reset, power-on values, then the scenarios
  initial begin
    {rst_n, voltage_detect_reset, thermal_shutdown_trip, resistor_diag_valid} = 4'h0;
    {supply_short_detect, ground_short_detect, resistor_diag_in} = 26'h0;
    {n_fail, samples_checked, cycles} = '0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(8'h41, 16'h0fff);
    rd_chk(8'h01, 16'h0000);
    t_locks();
    t_resets();
    t_sticky();
    tally_and_finish();
  end
endmodule
